// >>> hdl/nco_pkg.sv
// package with register map, field positions and reset values for the oscillator
package nco_pkg;
	localparam logic [3:0] NCO_OFS_ACC_LOW = 4'h0;
	localparam logic [3:0] NCO_OFS_ACC_HIGH = 4'h1;
	localparam logic [3:0] NCO_OFS_ACC_UPPER = 4'h2;
	localparam logic [3:0] NCO_OFS_STEP_LOW = 4'h3;
	localparam logic [3:0] NCO_OFS_STEP_HIGH = 4'h4;
	localparam logic [3:0] NCO_OFS_CONTROL = 4'h5;
	localparam logic [3:0] NCO_OFS_CLK_CFG = 4'h6;
	localparam logic [3:0] NCO_OFS_IRQ = 4'h7;
	localparam int NCO_CTL_EN_BIT = 7;
	localparam int NCO_CTL_OE_BIT = 6;
	localparam int NCO_CTL_OUT_BIT = 5;
	localparam int NCO_CTL_POL_BIT = 4;
	localparam int NCO_CTL_PFM_BIT = 0;
	localparam int NCO_CFG_PWS_LSB = 5;
	localparam int NCO_CFG_CKS_LSB = 0;
	localparam int NCO_IRQ_FLAG_BIT = 0;
	localparam int NCO_IRQ_IE_BIT = 1;
	localparam int NCO_IRQ_PERIPHERAL_IRQ_MASTER_ENABLE_BIT = 2;
	localparam int NCO_IRQ_GIE_BIT = 3;
	localparam logic [19:0] NCO_ACC_RST = 20'h00000;
	localparam logic [15:0] NCO_STEP_RST = 16'h0000;
	localparam logic [7:0] NCO_BYTE_RST = 8'h00;
	localparam logic [2:0] NCO_CKS_FAST_OSC = 3'h0;
	localparam logic [2:0] NCO_CKS_SYS_OSC = 3'h1;
	localparam logic [2:0] NCO_CKS_LOGIC_CELL = 3'h2;
	localparam logic [2:0] NCO_CKS_EXT_PIN = 3'h3;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} nco_bus_req_s;

	typedef struct packed {
		logic enable;
		logic pin_oe;
		logic polarity;
		logic pulse_mode;
		logic [2:0] width_sel;
		logic [2:0] clk_sel;
	} nco_cfg_s;
endpackage : nco_pkg

// >>> hdl/nco_top.sv
// numerically controlled oscillator with byte register port and pulse shaping
//
// Contract
// - twenty-bit phase accumulator is core state
// - accumulator readable/writable as three byte registers
// - accumulator adds step on selected clock edge
// - accumulator carry is raw oscillator output
// - sixteen-bit step from low and high bytes
// - hidden step buffer, loaded immediately when disabled
// - enabled: high first, load after low write
// - three-bit select chooses one of four clocks
// - toggle mode flips output on each overflow
// - pulse mode holds output active after overflow
// - pulse goes active on next clock edge
// - three-bit field sets pulse width in periods
// - polarity is final output stage
// - polarity change raises interrupt for transition
// - output readable, routed internally and to pin
// - overflow sets interrupt flag
// - interrupt needs enable, ie, peripheral_irq_master_enable and gie
// - reset clears every register to zero
// - keeps running in sleep while clock runs
// - fast oscillator kept on in sleep when used
// - module enable bit runs or stops oscillator
// - pin driven only when output enable set
// - polarity one active-high, zero active-low
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module nco_top
	import nco_pkg::*;
#(
	parameter int ACC_W = 20,
	parameter int STEP_W = 16,
	parameter int MAX_WIDTH_SEL = 7
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// clock sources, sampled as synchronous inputs
	input wire logic fast_osc_clk_i,
	input wire logic sys_osc_clk_i,
	input wire logic logic_cell_output_i,
	input wire logic ext_clock_input_i,
	// system status
	input wire logic sleep_i,
	// outputs
	output logic nco_out_o,
	output logic pin_out_o,
	output logic pin_oe_o,
	output logic irq_o,
	output logic fast_osc_keep_o
);
	initial begin
		if (ACC_W != 20 || STEP_W != 16 || MAX_WIDTH_SEL < 0 || MAX_WIDTH_SEL > 7) begin
			$error("nco_top: unsupported parameters");
		end
	end

	localparam int CNT_W = 8;

	function automatic logic [CNT_W-1:0] width_periods(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > 3'(MAX_WIDTH_SEL)) ? 3'(MAX_WIDTH_SEL) : sel;
		width_periods = CNT_W'(1) << s;
	endfunction : width_periods

	function automatic logic sel_reg(input nco_bus_req_s r, input logic [3:0] ofs);
		sel_reg = r.addr == ofs;
	endfunction : sel_reg

	nco_bus_req_s req;
	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

	nco_cfg_s cfg_q;
	logic [ACC_W-1:0] acc_q;
	logic [STEP_W-1:0] step_q;
	logic [STEP_W-1:0] step_buf_q;
	logic step_load_pend_q;
	logic irq_flag_q, irq_ie_q, irq_peripheral_irq_master_enable_q, irq_gie_q;
	logic shaped_q;
	logic [CNT_W-1:0] pulse_cnt_q;
	logic src_q, src_prev_q;
	logic out_level_q;

	// clock select; sources are sampled synchronous inputs
	logic src_sel;
	always_comb begin
		unique case (cfg_q.clk_sel)
			NCO_CKS_FAST_OSC: src_sel = fast_osc_clk_i;
			NCO_CKS_SYS_OSC: src_sel = sys_osc_clk_i;
			NCO_CKS_LOGIC_CELL: src_sel = logic_cell_output_i;
			NCO_CKS_EXT_PIN: src_sel = ext_clock_input_i;
			default: src_sel = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			src_q <= 1'b0;
			src_prev_q <= 1'b0;
		end else begin
			src_q <= src_sel;
			src_prev_q <= src_q;
		end
	end

	// rising edge of the selected input clock, gated by enable
	logic tick;
	assign tick = cfg_q.enable && src_q && !src_prev_q;

	logic [ACC_W:0] sum;
	assign sum = {1'b0, acc_q} + {{(ACC_W + 1 - STEP_W){1'b0}}, step_buf_q};
	logic overflow;
	assign overflow = tick && sum[ACC_W];

	logic wr_acc_l, wr_acc_h, wr_acc_u, wr_step_l, wr_step_h, wr_ctl, wr_cfg, wr_irq;
	assign wr_acc_l = req.wr && sel_reg(req, NCO_OFS_ACC_LOW);
	assign wr_acc_h = req.wr && sel_reg(req, NCO_OFS_ACC_HIGH);
	assign wr_acc_u = req.wr && sel_reg(req, NCO_OFS_ACC_UPPER);
	assign wr_step_l = req.wr && sel_reg(req, NCO_OFS_STEP_LOW);
	assign wr_step_h = req.wr && sel_reg(req, NCO_OFS_STEP_HIGH);
	assign wr_ctl = req.wr && sel_reg(req, NCO_OFS_CONTROL);
	assign wr_cfg = req.wr && sel_reg(req, NCO_OFS_CLK_CFG);
	assign wr_irq = req.wr && sel_reg(req, NCO_OFS_IRQ);

	// accumulator; software write wins over an addition in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_q <= NCO_ACC_RST;
		end else if (wr_acc_l) begin
			acc_q[7:0] <= req.wdata;
		end else if (wr_acc_h) begin
			acc_q[15:8] <= req.wdata;
		end else if (wr_acc_u) begin
			acc_q[19:16] <= req.wdata[3:0];
		end else if (tick) begin
			acc_q <= sum[ACC_W-1:0];
		end
	end

	// visible step registers
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			step_q <= NCO_STEP_RST;
		end else if (wr_step_l) begin
			step_q[7:0] <= req.wdata;
		end else if (wr_step_h) begin
			step_q[15:8] <= req.wdata;
		end
	end

	// hidden step buffer
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			step_buf_q <= NCO_STEP_RST;
			step_load_pend_q <= 1'b0;
		end else if (!cfg_q.enable) begin
			step_buf_q <= step_q;
			step_load_pend_q <= 1'b0;
		end else if (wr_step_l) begin
			step_load_pend_q <= 1'b1;
		end else if (step_load_pend_q && tick) begin
			step_buf_q <= step_q;
			step_load_pend_q <= 1'b0;
		end
	end

	// control and clock configuration
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_q <= '0;
		end else begin
			if (wr_ctl) begin
				cfg_q.enable <= req.wdata[NCO_CTL_EN_BIT];
				cfg_q.pin_oe <= req.wdata[NCO_CTL_OE_BIT];
				cfg_q.polarity <= req.wdata[NCO_CTL_POL_BIT];
				cfg_q.pulse_mode <= req.wdata[NCO_CTL_PFM_BIT];
			end
			if (wr_cfg) begin
				cfg_q.width_sel <= req.wdata[NCO_CFG_PWS_LSB +: 3];
				cfg_q.clk_sel <= req.wdata[NCO_CFG_CKS_LSB +: 3];
			end
		end
	end

	// shaping: toggle or stretched pulse, active-high before polarity
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shaped_q <= 1'b0;
			pulse_cnt_q <= '0;
		end else if (!cfg_q.pulse_mode) begin
			pulse_cnt_q <= '0;
			if (overflow) begin
				shaped_q <= !shaped_q;
			end
		end else if (overflow) begin
			shaped_q <= 1'b1;
			pulse_cnt_q <= width_periods(cfg_q.width_sel);
		end else if (tick && shaped_q) begin
			if (pulse_cnt_q <= CNT_W'(1)) begin
				shaped_q <= 1'b0;
				pulse_cnt_q <= '0;
			end else begin
				pulse_cnt_q <= pulse_cnt_q - CNT_W'(1);
			end
		end
	end

	// polarity stage
	logic level_d;
	assign level_d = cfg_q.polarity ? shaped_q : !shaped_q;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_level_q <= 1'b0;
			nco_out_o <= 1'b0;
			pin_out_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			out_level_q <= level_d;
			nco_out_o <= level_d;
			pin_out_o <= level_d;
			pin_oe_o <= cfg_q.pin_oe;
		end
	end

	// output transition caused by a polarity change
	logic pol_change_q;
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pol_change_q <= 1'b0;
		end else begin
			pol_change_q <= wr_ctl && (req.wdata[NCO_CTL_POL_BIT] != cfg_q.polarity);
		end
	end

	logic irq_event;
	assign irq_event = overflow || (pol_change_q && irq_ie_q && (out_level_q != level_d));

	// interrupt flag and enables; a set wins over a software clear
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_flag_q <= 1'b0;
			irq_ie_q <= 1'b0;
			irq_peripheral_irq_master_enable_q <= 1'b0;
			irq_gie_q <= 1'b0;
		end else begin
			if (wr_irq) begin
				irq_ie_q <= req.wdata[NCO_IRQ_IE_BIT];
				irq_peripheral_irq_master_enable_q <= req.wdata[NCO_IRQ_PERIPHERAL_IRQ_MASTER_ENABLE_BIT];
				irq_gie_q <= req.wdata[NCO_IRQ_GIE_BIT];
			end
			if (irq_event) begin
				irq_flag_q <= 1'b1;
			end else if (wr_irq) begin
				irq_flag_q <= req.wdata[NCO_IRQ_FLAG_BIT];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
			fast_osc_keep_o <= 1'b0;
		end else begin
			irq_o <= irq_flag_q && cfg_q.enable && irq_ie_q && irq_peripheral_irq_master_enable_q && irq_gie_q;
			fast_osc_keep_o <= sleep_i && cfg_q.enable && (cfg_q.clk_sel == NCO_CKS_FAST_OSC);
		end
	end

	// read port; unmapped addresses read zero
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= NCO_BYTE_RST;
		end else if (req.rd) begin
			unique case (req.addr)
				NCO_OFS_ACC_LOW: reg_rdata_o <= acc_q[7:0];
				NCO_OFS_ACC_HIGH: reg_rdata_o <= acc_q[15:8];
				NCO_OFS_ACC_UPPER: reg_rdata_o <= {4'h0, acc_q[19:16]};
				NCO_OFS_STEP_LOW: reg_rdata_o <= step_q[7:0];
				NCO_OFS_STEP_HIGH: reg_rdata_o <= step_q[15:8];
				NCO_OFS_CONTROL: reg_rdata_o <= {cfg_q.enable, cfg_q.pin_oe, out_level_q, cfg_q.polarity,
					3'h0, cfg_q.pulse_mode};
				NCO_OFS_CLK_CFG: reg_rdata_o <= {cfg_q.width_sel, 2'h0, cfg_q.clk_sel};
				NCO_OFS_IRQ: reg_rdata_o <= {4'h0, irq_gie_q, irq_peripheral_irq_master_enable_q, irq_ie_q, irq_flag_q};
				default: reg_rdata_o <= NCO_BYTE_RST;
			endcase
		end else begin
			reg_rdata_o <= NCO_BYTE_RST;
		end
	end
endmodule : nco_top

// >>> verif/nco_far_end.sv
// far-side model: source clock maker and pin consumer
`timescale 1ns/1ps
module nco_far_end (
	// clock
	input wire logic core_clk_i,
	// oscillator pin
	input wire logic pin_out_i,
	input wire logic pin_oe_i,
	// source clock and pin level
	output logic src_clk_o,
	output wire logic pin_level_o
);
	// pull-up when the block leaves the pin
	assign pin_level_o = pin_oe_i ? pin_out_i : 1'b1;
	initial src_clk_o = 1'b0;
	// source periods, still between calls
	task automatic tick(input int n);
		repeat (n) begin
			repeat (4) @(posedge core_clk_i);
			src_clk_o <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			src_clk_o <= 1'b0;
		end
		repeat (8) @(posedge core_clk_i);
	endtask : tick
endmodule : nco_far_end

// >>> verif/nco_top_monitor.sv
// assertion checker watching the oscillator top ports
`timescale 1ns/1ps
module nco_top_monitor
	import nco_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// sources and status
	input wire logic fast_osc_clk_i,
	input wire logic sys_osc_clk_i,
	input wire logic logic_cell_output_i,
	input wire logic ext_clock_input_i,
	input wire logic sleep_i,
	// outputs
	input wire logic nco_out_o,
	input wire logic pin_out_o,
	input wire logic pin_oe_o,
	input wire logic irq_o,
	input wire logic fast_osc_keep_o
);
	logic src_q;
	logic [3:0] src_age_q;
	logic [3:0] wr_age_q;
	wire src_any = fast_osc_clk_i | sys_osc_clk_i | logic_cell_output_i | ext_clock_input_i;
	wire ctl_wr = reg_wr_i && reg_addr_i == NCO_OFS_CONTROL;
	// cycles since last source rise, saturating
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			src_q <= 1'b0;
			src_age_q <= 4'h0;
		end else begin
			src_q <= src_any;
			src_age_q <= (src_any && !src_q) ? 4'h0 : src_age_q + {3'h0, src_age_q != 4'hf};
		end
	end
	// cycles since last register write, saturating
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			wr_age_q <= 4'h0;
		else
			wr_age_q <= reg_wr_i ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_rdata_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
	property p_pin_match; pin_out_o == nco_out_o; endproperty
	a_pin_match: assert property (p_pin_match) else $error("pin level differs");
	property p_oe_cause; $changed(pin_oe_o) |-> $past(ctl_wr, 1) || $past(ctl_wr, 2); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
	property p_keep_sleep; fast_osc_keep_o |-> $past(sleep_i); endproperty
	a_keep_sleep: assert property (p_keep_sleep) else $error("keep without sleep");
	property p_reset_clear; $rose(rst_b_i) |-> !irq_o && !pin_oe_o && !nco_out_o && reg_rdata_o == 8'h00; endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
	property p_irq_fall; $fell(irq_o) |-> wr_age_q <= 4'h4; endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
	property p_out_cause; $changed(nco_out_o) |-> src_age_q <= 4'h9 || wr_age_q <= 4'h4; endproperty
	a_out_cause: assert property (p_out_cause) else $error("output moved alone");
	property p_irq_cause; $rose(irq_o) |-> src_age_q <= 4'h9 || wr_age_q <= 4'h4; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose alone");
	c_irq: cover property ($rose(irq_o));
	c_out_fall: cover property ($fell(nco_out_o));
	c_keep: cover property (fast_osc_keep_o);
endmodule : nco_top_monitor

// >>> verif/tb.sv
// testbench for the oscillator: register sequences against expected values
`timescale 1ns/1ps
module tb;
	import nco_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	nco_bus_req_s req = '0;
	logic sleep = 1'b0;
	logic [7:0] rdata;
	logic src, nco_out, pin_out, pin_oe, irq, keep;
	// which source input the far-end clock reaches; the others stay low
	logic [1:0] route = 2'h0;
	wire src_fast = src && route == 2'h0;
	wire src_sys = src && route == 2'h1;
	wire src_cell = src && route == 2'h2;
	wire src_ext = src && route == 2'h3;
	wire pin_level;
	int failures = 0;
	int compares = 0;
	always #5 core_clk_i = ~core_clk_i;
	nco_top i_nco_top (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(req.addr), .reg_wdata_i(req.wdata),
		.reg_wr_i(req.wr), .reg_rd_i(req.rd), .reg_rdata_o(rdata), .fast_osc_clk_i(src_fast),
		.sys_osc_clk_i(src_sys), .logic_cell_output_i(src_cell), .ext_clock_input_i(src_ext), .sleep_i(sleep),
		.nco_out_o(nco_out),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe), .irq_o(irq), .fast_osc_keep_o(keep));
	nco_far_end i_nco_far_end (.core_clk_i(core_clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .src_clk_o(src),
		.pin_level_o(pin_level));
	task automatic report_and_stop();
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_i);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk_i);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_i);
		req.rd <= 1'b0;
		#1 chk("rdata", {12'h000, rdata}, {12'h000, exp});
	endtask : rd
	task automatic set_acc(input logic [19:0] v);
		wr(NCO_OFS_ACC_LOW, v[7:0]);
		wr(NCO_OFS_ACC_HIGH, v[15:8]);
		wr(NCO_OFS_ACC_UPPER, {4'h0, v[19:16]});
	endtask : set_acc
	task automatic chk_acc(input logic [19:0] v);
		rd(NCO_OFS_ACC_LOW, v[7:0]);
		rd(NCO_OFS_ACC_HIGH, v[15:8]);
		rd(NCO_OFS_ACC_UPPER, {4'h0, v[19:16]});
	endtask : chk_acc
	initial begin
		#50000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		for (int a = 0; a < 9; a++) rd(a[3:0], a == 5 ? 8'h20 : 8'h00);
		wr(NCO_OFS_STEP_HIGH, 8'h00);
		wr(NCO_OFS_STEP_LOW, 8'h10);
		rd(NCO_OFS_STEP_LOW, 8'h10);
		set_acc(20'hffff0);
		chk_acc(20'hffff0);
		route <= 2'h1;
		wr(NCO_OFS_CLK_CFG, {3'h0, 2'h0, NCO_CKS_SYS_OSC});
		wr(NCO_OFS_IRQ, 8'h0e);
		wr(NCO_OFS_CONTROL, 8'hc0);
		i_nco_far_end.tick(1);
		chk_acc(20'h00000);
		chk("out", nco_out, 1'b0);
		chk("pin", pin_level, 1'b0);
		chk("irq", irq, 1'b1);
		rd(NCO_OFS_CONTROL, 8'hc0);
		wr(NCO_OFS_IRQ, 8'h0e);
		rd(NCO_OFS_IRQ, 8'h0e);
		chk("irq", irq, 1'b0);
		i_nco_far_end.tick(1);
		chk_acc(20'h00010);
		chk("out", nco_out, 1'b0);
		wr(NCO_OFS_CONTROL, 8'hd0);
		rd(NCO_OFS_IRQ, 8'h0f);
		chk("out", nco_out, 1'b1);
		wr(NCO_OFS_STEP_HIGH, 8'h80);
		i_nco_far_end.tick(1);
		chk_acc(20'h00020);
		wr(NCO_OFS_STEP_LOW, 8'h00);
		i_nco_far_end.tick(1);
		set_acc(20'hf8000);
		wr(NCO_OFS_CLK_CFG, 8'h21);
		wr(NCO_OFS_CONTROL, 8'hd1);
		i_nco_far_end.tick(1);
		chk_acc(20'h00000);
		chk("out", nco_out, 1'b1);
		i_nco_far_end.tick(2);
		chk("out", nco_out, 1'b0);
		for (int s = 0; s < 5; s++) begin
			route <= s[1:0];
			wr(NCO_OFS_CLK_CFG, {3'h1, 2'h0, s[2:0]});
			i_nco_far_end.tick(1);
			chk_acc(20'(20'h10000 + 20'h08000 * (s < 4 ? s + 1 : 4)));
		end
		wr(NCO_OFS_CLK_CFG, {3'h1, 2'h0, NCO_CKS_FAST_OSC});
		@(posedge core_clk_i);
		sleep <= 1'b1;
		i_nco_far_end.tick(1);
		chk("keep", keep, 1'b1);
		chk_acc(20'h38000);
		sleep <= 1'b0;
		wr(NCO_OFS_CONTROL, 8'h00);
		i_nco_far_end.tick(1);
		chk_acc(20'h38000);
		chk("pin", pin_level, 1'b1);
		report_and_stop();
	end
endmodule : tb
bind nco_top nco_top_monitor i_nco_top_monitor (.*);
